// ### verilog/pin_engine_pkg.sv
// Purpose: Shared constants and carriers of the PIN verify/change engine
// Assumes: One command per pulse, decoded upstream into an operation code
// Notes: Slot index is {P2 b8, P2 b5..b1}; slot numbers 0 and 32 can never be named by a command
package pin_engine_pkg;

    // Retry counter
    localparam logic [1:0] RETRY_INIT = 2'h3;
    localparam logic [1:0] RETRY_NONE = 2'h0;

    // Command field layout
    localparam logic [7:0] LC_EMPTY = 8'h00;
    localparam logic [7:0] LC_VERIFY = 8'h08;
    localparam logic [7:0] LC_CHANGE = 8'h10;
    localparam logic [7:0] P1_ZERO = 8'h00;
    localparam int P2_SCOPE_BIT = 7;
    localparam logic [1:0] P2_RFU_ZERO = 2'h0;
    localparam logic [4:0] KEY_REF_NONE = 5'h00;

    // Status words
    localparam logic [15:0] SW_OK = 16'h9000;
    localparam logic [15:0] SW_RETRY_BASE = 16'h63c0;
    localparam logic [15:0] SW_BLOCKED = 16'h6983;
    localparam logic [15:0] SW_NOT_USABLE = 16'h6984;
    localparam logic [15:0] SW_WRONG_LEN = 16'h6700;
    localparam logic [15:0] SW_BAD_P1P2 = 16'h6a86;
    localparam logic [15:0] SW_BAD_INS = 16'h6d00;

    // Register offsets (byte addresses)
    localparam logic [7:0] REG_SLOT_SEL = 8'h00;
    localparam logic [7:0] REG_REF_LO = 8'h04;
    localparam logic [7:0] REG_REF_HI = 8'h08;
    localparam logic [7:0] REG_ACTION = 8'h0c;
    localparam logic [7:0] REG_SLOT_STATE = 8'h10;

    // Action register bits (write one to act)
    localparam int ACT_PROGRAM = 0;
    localparam int ACT_DISABLE = 1;
    localparam int ACT_ENABLE = 2;
    localparam int ACT_UNBLOCK = 3;

    // Slot state read layout: [1:0] count, [2] disabled, [3] verified, [4] blocked
    localparam int ST_DISABLED = 2;
    localparam int ST_VERIFIED = 3;
    localparam int ST_BLOCKED = 4;

    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_VERIFY = 2'b01,
        OP_CHANGE = 2'b10
    } pin_op_t;

    typedef struct packed {
        logic valid;
        pin_op_t op;
        logic [7:0] p1;
        logic [7:0] p2;
        logic [7:0] lc;
        logic [127:0] data;
    } pin_cmd_t;

    typedef struct packed {
        logic valid;
        logic [15:0] sw;
    } pin_rsp_t;

    typedef struct packed {
        logic valid;
        logic [5:0] slot;
    } access_req_t;

endpackage

// ### verilog/pin_verify_change_engine.sv
// Purpose: Card-side PIN verification, PIN change and retry-count query engine
// Assumes: Commands already framed; rst_in models loss of persistent state only
// Notes: Security status is one bit per PIN slot, shared by all logical channels
// Contract
// - Verified status valid on every logical channel
// - Verify compares only if enabled, unblocked
// - PIN-protected function needs verified or disabled PIN
// - Correct verify restores counter to three
// - Wrong PIN decrements counter on any channel
// - First fail 63C2, second fail 63C1
// - Third fail blocks PIN, answers 63C0
// - Verify data on blocked PIN gives 6983
// - Blocked PIN never satisfies until unblocked
// - Empty verify returns retries as 63CX
// - Empty verify on blocked PIN 63C0
// - P2 b8 scope, b7 b6 zero, nonzero
// - P2 low five bits are reference 01-1F
// - Change only when enabled and unblocked
// - Old PIN match: counter three, new PIN
// - Changed PIN visible to all channels
// - Old PIN mismatch decrements, keeps PIN, blocks
module pin_verify_change_engine (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Session start clears security status only
    input wire logic session_start_in,
    // Command and response
    input wire pin_engine_pkg::pin_cmd_t cmd_in,
    output pin_engine_pkg::pin_rsp_t rsp_out,
    // Access condition check
    input wire pin_engine_pkg::access_req_t access_in,
    output logic access_ok_out,
    output logic access_valid_out,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out
);

    function automatic logic [5:0] slot_of(input logic [7:0] p2);
        slot_of = {p2[pin_engine_pkg::P2_SCOPE_BIT], p2[4:0]};
    endfunction

    function automatic logic [15:0] retry_sw(input logic [1:0] cnt);
        retry_sw = pin_engine_pkg::SW_RETRY_BASE | {14'h0000, cnt};
    endfunction

    // Per-slot state; ver_r is global, not per channel
    logic [63:0] ref_r [64];
    logic [63:0] ref_nxt [64];
    logic [1:0] cnt_r [64];
    logic [1:0] cnt_nxt [64];
    logic [63:0] dis_r;
    logic [63:0] dis_nxt;
    logic [63:0] ver_r;
    logic [63:0] ver_nxt;

    // Provisioning staging
    logic [5:0] sel_r;
    logic [5:0] sel_nxt;
    logic [31:0] lo_r;
    logic [31:0] lo_nxt;
    logic [31:0] hi_r;
    logic [31:0] hi_nxt;

    // Output flops
    pin_engine_pkg::pin_rsp_t rsp_r;
    pin_engine_pkg::pin_rsp_t rsp_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic acc_ok_r;
    logic acc_ok_nxt;
    logic acc_vld_r;
    logic acc_vld_nxt;

    logic [5:0] s;
    logic blk;
    logic p2_ok;
    logic [63:0] presented;
    logic [1:0] dec;

    assign s = slot_of(cmd_in.p2);
    assign blk = (cnt_r[s] == pin_engine_pkg::RETRY_NONE);
    assign p2_ok = (cmd_in.p2[6:5] == pin_engine_pkg::P2_RFU_ZERO) &&
                   (cmd_in.p2[4:0] != pin_engine_pkg::KEY_REF_NONE);
    assign presented = cmd_in.data[127:64];
    assign dec = cnt_r[s] - 2'h1;

    always_comb begin
        ref_nxt = ref_r;
        cnt_nxt = cnt_r;
        dis_nxt = dis_r;
        ver_nxt = ver_r;
        sel_nxt = sel_r;
        lo_nxt = lo_r;
        hi_nxt = hi_r;
        rsp_nxt = '0;
        rdata_nxt = 32'h0000_0000;
        // Session boundary drops security status; counters persist
        if (session_start_in) begin
            ver_nxt = 64'h0000_0000_0000_0000;
        end
        // Software provisioning; a command of the same cycle sees the old state and its updates win
        if (reg_wr_in) begin
            case (reg_addr_in)
                pin_engine_pkg::REG_SLOT_SEL: sel_nxt = reg_wdata_in[5:0];
                pin_engine_pkg::REG_REF_LO: lo_nxt = reg_wdata_in;
                pin_engine_pkg::REG_REF_HI: hi_nxt = reg_wdata_in;
                pin_engine_pkg::REG_ACTION: begin
                    if (reg_wdata_in[pin_engine_pkg::ACT_PROGRAM]) begin
                        ref_nxt[sel_r] = {hi_r, lo_r};
                        cnt_nxt[sel_r] = pin_engine_pkg::RETRY_INIT;
                        ver_nxt[sel_r] = 1'b0;
                    end
                    if (reg_wdata_in[pin_engine_pkg::ACT_DISABLE]) begin
                        dis_nxt[sel_r] = 1'b1;
                    end
                    if (reg_wdata_in[pin_engine_pkg::ACT_ENABLE]) begin
                        dis_nxt[sel_r] = 1'b0;
                    end
                    // One of two paths out of the blocked state; ACT_PROGRAM also reloads the count
                    if (reg_wdata_in[pin_engine_pkg::ACT_UNBLOCK]) begin
                        cnt_nxt[sel_r] = pin_engine_pkg::RETRY_INIT;
                        dis_nxt[sel_r] = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // Reference words are write-only so a PIN can never be read back
        if (reg_rd_in) begin
            case (reg_addr_in)
                pin_engine_pkg::REG_SLOT_SEL: rdata_nxt = {26'h0000000, sel_r};
                pin_engine_pkg::REG_SLOT_STATE: begin
                    rdata_nxt[1:0] = cnt_r[sel_r];
                    rdata_nxt[pin_engine_pkg::ST_DISABLED] = dis_r[sel_r];
                    rdata_nxt[pin_engine_pkg::ST_VERIFIED] = ver_r[sel_r];
                    rdata_nxt[pin_engine_pkg::ST_BLOCKED] =
                        (cnt_r[sel_r] == pin_engine_pkg::RETRY_NONE);
                end
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
        // Command; one global state array serves all channels
        if (cmd_in.valid) begin
            rsp_nxt.valid = 1'b1;
            rsp_nxt.sw = pin_engine_pkg::SW_OK;
            if (!p2_ok || cmd_in.p1 != pin_engine_pkg::P1_ZERO) begin
                rsp_nxt.sw = pin_engine_pkg::SW_BAD_P1P2;
            end else begin
                case (cmd_in.op)
                    pin_engine_pkg::OP_VERIFY: begin
                        if (cmd_in.lc == pin_engine_pkg::LC_EMPTY) begin
                            // Blocked slot has count zero, so this reads 63C0
                            rsp_nxt.sw = retry_sw(cnt_r[s]);
                        end else if (cmd_in.lc != pin_engine_pkg::LC_VERIFY) begin
                            rsp_nxt.sw = pin_engine_pkg::SW_WRONG_LEN;
                        end else if (blk) begin
                            rsp_nxt.sw = pin_engine_pkg::SW_BLOCKED;
                        end else if (dis_r[s]) begin
                            rsp_nxt.sw = pin_engine_pkg::SW_NOT_USABLE;
                        end else if (presented == ref_r[s]) begin
                            cnt_nxt[s] = pin_engine_pkg::RETRY_INIT;
                            ver_nxt[s] = 1'b1;
                            rsp_nxt.sw = pin_engine_pkg::SW_OK;
                        end else begin
                            cnt_nxt[s] = dec;
                            ver_nxt[s] = 1'b0;
                            rsp_nxt.sw = retry_sw(dec);
                        end
                    end
                    pin_engine_pkg::OP_CHANGE: begin
                        if (cmd_in.lc != pin_engine_pkg::LC_CHANGE) begin
                            rsp_nxt.sw = pin_engine_pkg::SW_WRONG_LEN;
                        end else if (blk) begin
                            rsp_nxt.sw = pin_engine_pkg::SW_BLOCKED;
                        end else if (dis_r[s]) begin
                            rsp_nxt.sw = pin_engine_pkg::SW_NOT_USABLE;
                        end else if (presented == ref_r[s]) begin
                            cnt_nxt[s] = pin_engine_pkg::RETRY_INIT;
                            ref_nxt[s] = cmd_in.data[63:0];
                            rsp_nxt.sw = pin_engine_pkg::SW_OK;
                        end else begin
                            // Reaching zero is the blocked state
                            cnt_nxt[s] = dec;
                            ver_nxt[s] = 1'b0;
                            rsp_nxt.sw = retry_sw(dec);
                        end
                    end
                    default: rsp_nxt.sw = pin_engine_pkg::SW_BAD_INS;
                endcase
            end
        end
        // Access check sees state before this cycle's command
        acc_vld_nxt = access_in.valid;
        acc_ok_nxt = 1'b0;
        if (access_in.valid) begin
            acc_ok_nxt = (cnt_r[access_in.slot] != pin_engine_pkg::RETRY_NONE) &&
                         (ver_r[access_in.slot] || dis_r[access_in.slot]);
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < 64; i++) begin
                ref_r[i] <= 64'h0000_0000_0000_0000;
                cnt_r[i] <= pin_engine_pkg::RETRY_INIT;
            end
            dis_r <= 64'h0000_0000_0000_0000;
            ver_r <= 64'h0000_0000_0000_0000;
            sel_r <= 6'h00;
            lo_r <= 32'h0000_0000;
            hi_r <= 32'h0000_0000;
            rsp_r <= '0;
            rdata_r <= 32'h0000_0000;
            acc_ok_r <= 1'b0;
            acc_vld_r <= 1'b0;
        end else begin
            ref_r <= ref_nxt;
            cnt_r <= cnt_nxt;
            dis_r <= dis_nxt;
            ver_r <= ver_nxt;
            sel_r <= sel_nxt;
            lo_r <= lo_nxt;
            hi_r <= hi_nxt;
            rsp_r <= rsp_nxt;
            rdata_r <= rdata_nxt;
            acc_ok_r <= acc_ok_nxt;
            acc_vld_r <= acc_vld_nxt;
        end
    end

    assign rsp_out = rsp_r;
    assign reg_rdata_out = rdata_r;
    assign access_ok_out = acc_ok_r;
    assign access_valid_out = acc_vld_r;

endmodule

// ### sim/terminal_model.sv
// Purpose: Terminal side that frames verify and change commands
// Assumes: One command in flight; the answer is registered on the same edge that takes the command
// Notes: Idle data bits are inverted so stale bytes never pass for a PIN
module terminal_model (
    // Clock
    input wire logic core_clk_in,
    // Command and response
    output pin_engine_pkg::pin_cmd_t cmd_out,
    input wire pin_engine_pkg::pin_rsp_t rsp_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial cmd_out = '0;
    // Returns unknown when no answer came, so a silent engine never matches
    task automatic send(input pin_engine_pkg::pin_op_t op, input logic [7:0] p2, lc,
        input logic [127:0] d, output logic [15:0] sw);
        @(posedge core_clk_in);
        cmd_out <= '{1'b1, op, pin_engine_pkg::P1_ZERO, p2, lc, d};
        @(posedge core_clk_in);
        cmd_out.valid <= 1'b0;
        cmd_out.data <= ~d;
        #1;
        sw = rsp_in.valid ? rsp_in.sw : 16'hxxxx;
    endtask
endmodule

// ### sim/pin_engine_monitor.sv
// Purpose: Port checks of the PIN verify/change engine
// Assumes: Bound to the engine top module
// Notes: Multi-step checks watch slot 1 only, to keep the checker small
module pin_engine_monitor (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Watched ports
    input wire logic session_start_in,
    input wire pin_engine_pkg::pin_cmd_t cmd_in,
    input wire pin_engine_pkg::pin_rsp_t rsp_out,
    input wire pin_engine_pkg::access_req_t access_in,
    input wire logic access_ok_out,
    input wire logic access_valid_out,
    input wire logic reg_wr_in
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    wire logic verify_slot1 = cmd_in.valid && cmd_in.op == pin_engine_pkg::OP_VERIFY
        && cmd_in.p2 == 8'h01;
    // Register actions could unblock or reprogram the slot mid-sequence
    wire logic quiet = !session_start_in && !reg_wr_in;
    sequence pass_s;
        verify_slot1 ##1 rsp_out.sw == pin_engine_pkg::SW_OK && quiet && !cmd_in.valid;
    endsequence
    sequence third_fail_s;
        verify_slot1 && cmd_in.lc == 8'h08 ##1 rsp_out.sw == 16'h63c0 && quiet
        ##1 verify_slot1 && cmd_in.lc == 8'h08 && cmd_in.p1 == 8'h00 && quiet;
    endsequence
    rsp_pulse_a: assert property (rsp_out.valid == $past(cmd_in.valid))
        else $error("response pulse out of step with command");
    bad_ref_a: assert property (cmd_in.valid && cmd_in.p2[4:0] == 5'h00 |=>
        rsp_out.sw == pin_engine_pkg::SW_BAD_P1P2) else $error("zero key reference taken");
    rfu_bits_a: assert property (cmd_in.valid && cmd_in.p2[6:5] != 2'h0 |=>
        rsp_out.sw == pin_engine_pkg::SW_BAD_P1P2) else $error("reserved qualifier bits taken");
    retry_range_a: assert property (rsp_out.valid && rsp_out.sw[15:4] == 12'h63c |->
        rsp_out.sw[3:0] <= 4'h3) else $error("retry count above three");
    access_echo_a: assert property (access_valid_out == $past(access_in.valid))
        else $error("access answer out of step");
    access_idle_a: assert property (!access_valid_out |-> !access_ok_out)
        else $error("access granted without a request");
    verify_pass_a: assert property (pass_s ##1 access_in.valid &&
        access_in.slot == 6'h01 |=> access_ok_out) else $error("verified PIN not honoured");
    blocked_answer_a: assert property (third_fail_s |=>
        rsp_out.sw == pin_engine_pkg::SW_BLOCKED) else $error("blocked PIN still compared");
endmodule

bind pin_verify_change_engine pin_engine_monitor u_mon (
    .core_clk_in, .rst_in, .session_start_in, .cmd_in, .rsp_out,
    .access_in, .access_ok_out, .access_valid_out, .reg_wr_in
);

// ### sim/pin_verify_change_engine_tb.sv
// Purpose: Self-checking bench of the PIN verify/change engine
// Assumes: Terminal model frames commands; registers driven here
// Notes: Slot 1 holds the test PIN; slot 33 keeps a zero reference
module pin_verify_change_engine_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] PIN_A = 64'h3132333435ffffff;
    localparam logic [63:0] PIN_B = 64'h3938373635ffffff;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic session_start_in = 1'b0;
    pin_engine_pkg::pin_cmd_t cmd_in;
    pin_engine_pkg::pin_rsp_t rsp_out;
    pin_engine_pkg::access_req_t access_in = '0;
    logic access_ok_out;
    logic access_valid_out;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [31:0] reg_rdata_out;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    always #5 core_clk_in = ~core_clk_in;
    pin_verify_change_engine u_dut (
        .core_clk_in, .rst_in, .session_start_in, .cmd_in, .rsp_out, .access_in,
        .access_ok_out, .access_valid_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out
    );
    terminal_model u_term (.core_clk_in, .cmd_out(cmd_in), .rsp_in(rsp_out));
    task automatic chk(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic send(input pin_engine_pkg::pin_op_t op, input logic [7:0] p2, lc,
        input logic [127:0] d, input logic [15:0] exp);
        logic [15:0] sw;
        u_term.send(op, p2, lc, d, sw);
        chk("sw", {16'h0, sw}, {16'h0, exp});
    endtask
    task automatic v(input logic [7:0] p2, input logic [63:0] pin, input logic [15:0] exp);
        send(pin_engine_pkg::OP_VERIFY, p2, 8'h08, {pin, ~pin}, exp);
    endtask
    task automatic q(input logic [15:0] exp);
        send(pin_engine_pkg::OP_VERIFY, 8'h01, 8'h00, '1, exp);
    endtask
    task automatic c(input logic [63:0] o, n, input logic [15:0] exp);
        send(pin_engine_pkg::OP_CHANGE, 8'h01, 8'h10, {o, n}, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk("reg", reg_rdata_out, exp);
    endtask
    task automatic acc(input logic exp);
        @(posedge core_clk_in);
        access_in <= '{1'b1, 6'h01};
        @(posedge core_clk_in);
        access_in <= '0;
        #1;
        chk("acc", {30'h0, access_valid_out, access_ok_out}, {30'h0, 1'b1, exp});
    endtask
    task automatic session();
        @(posedge core_clk_in);
        session_start_in <= 1'b1;
        @(posedge core_clk_in);
        session_start_in <= 1'b0;
    endtask
    task automatic t_setup();
        wr(pin_engine_pkg::REG_SLOT_SEL, 32'h1);
        wr(pin_engine_pkg::REG_REF_LO, PIN_A[31:0]);
        wr(pin_engine_pkg::REG_REF_HI, PIN_A[63:32]);
        wr(pin_engine_pkg::REG_ACTION, 32'h1);
        rd(8'h14, 32'h0);
        q(16'h63c3);
        acc(1'b0);
        v(8'h81, PIN_A, 16'h63c2);
        v(8'h01, PIN_A, 16'h9000);
        acc(1'b1);
    endtask
    task automatic t_block();
        v(8'h01, PIN_B, 16'h63c2);
        rd(pin_engine_pkg::REG_SLOT_STATE, 32'h2);
        v(8'h01, PIN_A, 16'h9000);
        rd(pin_engine_pkg::REG_SLOT_STATE, 32'hb);
        v(8'h01, PIN_B, 16'h63c2);
        v(8'h01, PIN_B, 16'h63c1);
        session();
        v(8'h01, PIN_B, 16'h63c0);
        v(8'h01, PIN_A, 16'h6983);
        q(16'h63c0);
        c(PIN_A, PIN_B, 16'h6983);
        acc(1'b0);
        rd(pin_engine_pkg::REG_SLOT_STATE, 32'h10);
        wr(pin_engine_pkg::REG_ACTION, 32'h8);
        v(8'h01, PIN_A, 16'h9000);
    endtask
    task automatic t_change();
        c(PIN_B, PIN_B, 16'h63c2);
        v(8'h01, PIN_A, 16'h9000);
        c(PIN_A, PIN_B, 16'h9000);
        rd(pin_engine_pkg::REG_SLOT_STATE, 32'hb);
        v(8'h01, PIN_A, 16'h63c2);
        v(8'h01, PIN_B, 16'h9000);
    endtask
    task automatic t_disabled();
        logic [7:0] bad [3] = '{8'h00, 8'h41, 8'h80};
        session();
        wr(pin_engine_pkg::REG_ACTION, 32'h2);
        v(8'h01, PIN_A, 16'h6984);
        q(16'h63c3);
        acc(1'b1);
        c(PIN_B, PIN_A, 16'h6984);
        wr(pin_engine_pkg::REG_ACTION, 32'h4);
        acc(1'b0);
        foreach (bad[i]) v(bad[i], PIN_B, 16'h6a86);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Whole run needs under a hundred cycles; the ceiling only catches a hang
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        repeat (8) @(posedge core_clk_in);
        rst_in <= 1'b0;
        t_setup();
        t_block();
        t_change();
        t_disabled();
        results();
    end
endmodule
